// ---- inc/smx_pkg.sv ----
// Purpose : shared constants and types for the sample interleave mapper
// Assumes : one clock domain on the cleaned reference clock
// Notes   : lane numbering is zero based inside the logic
package smx_pkg;
  localparam int unsigned SAMPLE_W       = 24;       // audio word width
  localparam int unsigned SOURCES        = 8;        // high-rate sources
  localparam int unsigned LINK_CH        = 8;        // channels per optical port
  localparam int unsigned PORTS          = 2;        // optical ports
  localparam int unsigned QUAD_SOURCES   = 4;        // sources carried in quad mode
  localparam int unsigned QUAD_CH_LIMIT  = 18;       // channel ceiling in quad mode
  localparam int unsigned BASE_441_HZ    = 44100;
  localparam int unsigned BASE_48_HZ     = 48000;
  localparam int unsigned LINK_MAX_HZ    = 48000;    // optical frame ceiling
  localparam logic [1:0]  FACTOR_SINGLE  = 2'h1;
  localparam logic [1:0]  FACTOR_DOUBLE  = 2'h2;
  localparam logic [1:0]  FACTOR_QUAD    = 2'h0;     // two-bit slot count wraps at four
  typedef enum logic [1:0] {
    SMX_SINGLE,
    SMX_DOUBLE,
    SMX_QUAD
  } smx_rate_t;
endpackage : smx_pkg

// ---- rtl/smx_slot_ctr.sv ----
// Purpose : counts high-rate sample slots inside one base-rate frame
// Assumes : slot_tick pulses once per high-rate sample period
// Notes   : frame_tick marks the last slot of a frame
`timescale 1ns/1ps
module smx_slot_ctr (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             slot_tick,
  input  wire smx_pkg::smx_rate_t rate,
  output logic [1:0]            slot,
  output logic                  frame_tick
);
  import smx_pkg::*;
  logic [1:0] slot_last;

  // last slot index depends on the multiplication factor
  always_comb begin
    case (rate)
      SMX_DOUBLE: slot_last = 2'h1;
      SMX_QUAD:   slot_last = 2'h3;
      default:    slot_last = 2'h0;
    endcase
  end

  // slot counter; restarts on every frame so a rate change cannot desync lanes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot <= 2'h0;
    end else if (slot_tick) begin
      slot <= (slot >= slot_last) ? 2'h0 : slot + 2'h1;
    end
  end

  assign frame_tick = slot_tick && (slot >= slot_last);
endmodule : smx_slot_ctr

// ---- rtl/smx_mapper.sv ----
// Purpose : spreads high-rate audio sources over base-rate optical and double-wire lines, and back from the optical lines
// Assumes : ref_clk is the jitter-cleaned recovered clock; ticks are synchronous to it
// Notes   : rate selection is static between frames; changes take effect at a frame edge
//
// Behaviour
// - double mode runs sample clock at twice base
// - samples stay 24 bits wide at all rates
// - double-wire line carries one channel, odd/even subframes
// - double mode interleaves optical link automatically
// - double: sources 1-4 port one, 5-8 port two
// - quad: four channels per source, sources 5-8 dropped
// - optical frames always leave at base rate
// - cleaned clock times conversion and all outputs
// - quad mode offers at most 18 channels
`timescale 1ns/1ps
module smx_mapper #(
  parameter int unsigned SW = smx_pkg::SAMPLE_W
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  input  wire logic                              double_rate_mode,
  input  wire logic                              quadruple_rate_mode,
  input  wire logic                              base_is_48k,
  input  wire logic                              base_tick,
  input  wire logic                              slot_tick,
  input  wire logic [smx_pkg::SOURCES*SW-1:0]    src_sample,
  input  wire logic [smx_pkg::PORTS*smx_pkg::LINK_CH*SW-1:0] link_rx,
  input  wire logic                              link_rx_frame,
  output logic [smx_pkg::PORTS*smx_pkg::LINK_CH*SW-1:0] link_tx,
  output logic                                   link_tx_frame,
  output logic [2*SW-1:0]                        dw_tx,
  output logic                                   dw_tx_frame,
  output logic [smx_pkg::SOURCES*SW-1:0]         snk_sample,
  output logic                                   snk_valid,
  output logic [1:0]                             rate_factor,
  output logic [16:0]                            internal_rate_hz,
  output logic [4:0]                             channel_limit,
  output logic                                   active_rate_double,
  output logic                                   active_rate_quad
);
  import smx_pkg::*;

  initial begin
    if (SW != SAMPLE_W) $error("sample width must stay at the package width");
  end

  localparam int unsigned NL = PORTS * LINK_CH;

  //////////////////////////////////////////////////////////////////////////////
  // rate selection and slot tracking

  smx_rate_t rate;
  smx_rate_t next_rate;
  logic [1:0] slot;
  logic       frame_end;
  logic       slot_frame_tick;

  // quad wins when both requests are set; double lights the interleave itself
  always_comb begin
    if (quadruple_rate_mode)    next_rate = SMX_QUAD;
    else if (double_rate_mode)  next_rate = SMX_DOUBLE;
    else                        next_rate = SMX_SINGLE;
  end

  // rate only moves at a frame edge so no frame mixes two layouts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate <= SMX_SINGLE;
    end else if (base_tick) begin
      rate <= next_rate;
    end
  end

  smx_slot_ctr u_slot (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .slot_tick  (slot_tick),
    .rate       (rate),
    .slot       (slot),
    .frame_tick (slot_frame_tick)
  );
  assign frame_end = base_tick;

  //////////////////////////////////////////////////////////////////////////////
  // status outputs

  // reported internal rate is base times factor in single and double mode, twice base in quad
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_factor        <= FACTOR_SINGLE;
      internal_rate_hz   <= 17'(BASE_48_HZ);
      channel_limit      <= 5'h0;
      active_rate_double <= 1'b0;
      active_rate_quad   <= 1'b0;
    end else begin
      active_rate_double <= (rate == SMX_DOUBLE);
      active_rate_quad   <= (rate == SMX_QUAD);
      case (rate)
        SMX_DOUBLE: begin
          rate_factor      <= FACTOR_DOUBLE;
          internal_rate_hz <= base_is_48k ? 17'(2*BASE_48_HZ) : 17'(2*BASE_441_HZ);
          channel_limit    <= 5'(SOURCES);
        end
        SMX_QUAD: begin
          rate_factor      <= FACTOR_QUAD;
          internal_rate_hz <= base_is_48k ? 17'(4*BASE_48_HZ/2) : 17'(4*BASE_441_HZ/2);
          channel_limit    <= 5'(QUAD_CH_LIMIT);
        end
        default: begin
          rate_factor      <= FACTOR_SINGLE;
          internal_rate_hz <= base_is_48k ? 17'(BASE_48_HZ) : 17'(BASE_441_HZ);
          channel_limit    <= 5'(SOURCES);
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit lane mapping

  // link lane fed by source s at slot k; -1 means not carried
  function automatic int tx_lane(input smx_rate_t r, input int s, input int k);
    int lane;
    lane = -1;
    case (r)
      SMX_DOUBLE: lane = (s / 4) * LINK_CH + (s % 4) * 2 + k;
      SMX_QUAD:   lane = (s < QUAD_SOURCES) ? s * 4 + k : -1;
      default:    lane = s;
    endcase
    return lane;
  endfunction : tx_lane

  logic [NL*SW-1:0] tx_acc;
  logic [NL*SW-1:0] next_tx_acc;
  logic [2*SW-1:0]  dw_acc;
  logic [2*SW-1:0]  next_dw_acc;

  // each slot drops every carried source word into its lane; merged view lets the last slot join the frame it closes
  always_comb begin
    next_tx_acc = tx_acc;
    if (slot_tick) begin
      for (int s = 0; s < SOURCES; s++) begin
        for (int l = 0; l < NL; l++) begin
          if (tx_lane(rate, s, int'(slot)) == l)
            next_tx_acc[l*SW +: SW] = src_sample[s*SW +: SW];
        end
      end
    end
  end

  // lane accumulator keeps the merged view
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_acc <= '0;
    end else begin
      tx_acc <= next_tx_acc;
    end
  end

  // double-wire: source one alone, odd sample left, even sample right
  always_comb begin
    next_dw_acc = dw_acc;
    if (slot_tick) begin
      next_dw_acc[slot[0]*SW +: SW] = src_sample[SW-1:0];
    end
  end

  // double-wire accumulator keeps the merged view
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dw_acc <= '0;
    end else begin
      dw_acc <= next_dw_acc;
    end
  end

  // frames leave only on the base tick, so link rate never exceeds base
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_tx       <= '0;
      link_tx_frame <= 1'b0;
      dw_tx         <= '0;
      dw_tx_frame   <= 1'b0;
    end else begin
      link_tx_frame <= frame_end;
      dw_tx_frame   <= frame_end;
      if (frame_end) begin
        link_tx <= next_tx_acc;
        dw_tx   <= next_dw_acc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive demultiplexing

  logic [NL*SW-1:0] rx_frame;
  logic             rx_have;

  // capture one link frame, then replay its slots in order
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_frame <= '0;
      rx_have  <= 1'b0;
    end else if (link_rx_frame) begin
      rx_frame <= link_rx;
      rx_have  <= 1'b1;
    end
  end

  // inverse mapping: same lane function, read instead of written
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      snk_sample <= '0;
      snk_valid  <= 1'b0;
    end else begin
      snk_valid <= slot_tick && rx_have;
      if (slot_tick) begin
        for (int s = 0; s < SOURCES; s++) begin
          snk_sample[s*SW +: SW] <= '0;
          for (int l = 0; l < NL; l++) begin
            if (tx_lane(rate, s, int'(slot)) == l)
              snk_sample[s*SW +: SW] <= rx_frame[l*SW +: SW];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_frame_base;
    @(posedge ref_clk) disable iff (!rst_b) base_tick |=> link_tx_frame;
  endproperty
  a_frame_base: assert property (p_frame_base) else $error("link frame not on base tick");

  property p_no_extra_frame;
    @(posedge ref_clk) disable iff (!rst_b) !base_tick |=> !link_tx_frame;
  endproperty
  a_no_extra_frame: assert property (p_no_extra_frame) else $error("link frame off base tick");

  property p_double_factor;
    @(posedge ref_clk) disable iff (!rst_b) rate == SMX_DOUBLE |=> rate_factor == FACTOR_DOUBLE;
  endproperty
  a_double_factor: assert property (p_double_factor) else $error("double factor wrong");

  property p_quad_limit;
    @(posedge ref_clk) disable iff (!rst_b) rate == SMX_QUAD |=> channel_limit == 5'(QUAD_CH_LIMIT);
  endproperty
  a_quad_limit: assert property (p_quad_limit) else $error("quad channel limit wrong");

  property p_auto_mux;
    @(posedge ref_clk) disable iff (!rst_b)
      base_tick && double_rate_mode && !quadruple_rate_mode |=> ##1 active_rate_double;
  endproperty
  a_auto_mux: assert property (p_auto_mux) else $error("double mode did not engage interleave");

  property p_frame_data;
    @(posedge ref_clk) disable iff (!rst_b) base_tick |=> link_tx == tx_acc;
  endproperty
  a_frame_data: assert property (p_frame_data) else $error("frame data not latched");

  // slot counter and base tick must agree, or lanes of two frames would mix
  property p_slot_align;
    @(posedge ref_clk) disable iff (!rst_b) slot_tick |-> (slot_frame_tick == base_tick);
  endproperty
  a_slot_align: assert property (p_slot_align) else $error("base tick off the last slot");

  property p_rx_valid;
    @(posedge ref_clk) disable iff (!rst_b) slot_tick && rx_have |=> snk_valid;
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("receive slot lost");

  property p_dw_frame;
    @(posedge ref_clk) disable iff (!rst_b) link_tx_frame |-> dw_tx_frame;
  endproperty
  a_dw_frame: assert property (p_dw_frame) else $error("double-wire frame out of step");

  c_double: cover property (@(posedge ref_clk) disable iff (!rst_b) active_rate_double ##1 link_tx_frame);
  c_quad:   cover property (@(posedge ref_clk) disable iff (!rst_b) active_rate_quad ##1 link_tx_frame);
  c_rx:     cover property (@(posedge ref_clk) disable iff (!rst_b) snk_valid);
endmodule : smx_mapper

// ---- dv/smx_link_partner.sv ----
// Purpose : far-side optical transceiver model that loops each transmit frame back
// Assumes : frames are marked by link_tx_frame strobes on ref_clk
// Notes   : reply delay is a parameter so a slow partner can be tried
`timescale 1ns/1ps
module smx_link_partner #(
  parameter int unsigned DELAY = 2
) (
  input  wire logic                                                   ref_clk,
  input  wire logic                                                   rst_b,
  input  wire logic [smx_pkg::PORTS*smx_pkg::LINK_CH*smx_pkg::SAMPLE_W-1:0] link_tx,
  input  wire logic                                                   link_tx_frame,
  output logic [smx_pkg::PORTS*smx_pkg::LINK_CH*smx_pkg::SAMPLE_W-1:0] link_rx,
  output logic                                                        link_rx_frame
);
  import smx_pkg::*;
  logic [PORTS*LINK_CH*SAMPLE_W-1:0] held;
  int unsigned                        wait_cnt;
  //////////////////////////////////////////////////////////////////////
  // replay lane for lane so slot order inside each group survives
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      held          <= '0;
      wait_cnt      <= 0;
      link_rx       <= '0;
      link_rx_frame <= 1'b0;
    end else begin
      link_rx_frame <= 1'b0;
      if (link_tx_frame) begin
        held     <= link_tx;
        wait_cnt <= DELAY;
      end else if (wait_cnt == 1) begin
        link_rx       <= held;
        link_rx_frame <= 1'b1; // one-cycle frame strobe, data held until next frame
        wait_cnt      <= 0;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : smx_link_partner

// ---- dv/tb_top.sv ----
// Purpose : self-checking bench for the sample interleave mapper
// Assumes : inputs change on the falling edge, rate latches at base_tick
// Notes   : each mode change is followed by a priming frame before data is judged
`timescale 1ns/1ps
module tb_top;
  import smx_pkg::*;
  logic                         ref_clk, rst_b, double_rate_mode, quadruple_rate_mode, base_is_48k;
  logic                         base_tick, slot_tick, link_rx_frame, link_tx_frame, dw_tx_frame, snk_valid;
  logic [SOURCES*SAMPLE_W-1:0]  src_sample, snk_sample;
  logic [PORTS*LINK_CH*SAMPLE_W-1:0] link_rx, link_tx;
  logic [2*SAMPLE_W-1:0]        dw_tx;
  logic [1:0]                   rate_factor;
  logic [16:0]                  internal_rate_hz;
  logic [4:0]                   channel_limit;
  logic                         active_rate_double, active_rate_quad;
  int                           err_total, comparisons, n_frames;
  smx_mapper i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .double_rate_mode(double_rate_mode),
    .quadruple_rate_mode(quadruple_rate_mode), .base_is_48k(base_is_48k), .base_tick(base_tick),
    .slot_tick(slot_tick), .src_sample(src_sample), .link_rx(link_rx), .link_rx_frame(link_rx_frame),
    .link_tx(link_tx), .link_tx_frame(link_tx_frame), .dw_tx(dw_tx), .dw_tx_frame(dw_tx_frame),
    .snk_sample(snk_sample), .snk_valid(snk_valid), .rate_factor(rate_factor),
    .internal_rate_hz(internal_rate_hz), .channel_limit(channel_limit),
    .active_rate_double(active_rate_double), .active_rate_quad(active_rate_quad));
  smx_link_partner i_partner (.ref_clk(ref_clk), .rst_b(rst_b), .link_tx(link_tx),
    .link_tx_frame(link_tx_frame), .link_rx(link_rx), .link_rx_frame(link_rx_frame));
  //////////////////////////////////////////////////////////////////////
  // clock and frame strobe counter
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (link_tx_frame === 1'b1) n_frames++;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] pat(input int s, input int k);
    return {4'(k + 1), 4'(s + 1), 16'hc35a}; // top nibble set to exercise the full word
  endfunction : pat
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : cmp
  // one base frame of n slots; optionally judges the demultiplexed sources per slot
  task automatic run_frame(input int n, input bit rx_chk, input bit quad_m);
    int nf;
    int i;
    nf = n_frames;
    for (int k = 0; k < n; k++) begin
      @(negedge ref_clk);
      for (int s = 0; s < SOURCES; s++) src_sample[s*SAMPLE_W+:SAMPLE_W] = pat(s, k);
      slot_tick = 1'b1;
      base_tick = (k == n - 1);
      @(negedge ref_clk);
      slot_tick = 1'b0;
      base_tick = 1'b0;
      if (rx_chk) begin
        cmp(snk_valid === 1'b1, "receive strobe missing");
        for (int s = 0; s < SOURCES; s++)
          cmp(snk_sample[s*SAMPLE_W+:SAMPLE_W] === ((quad_m && s >= 4) ? 24'h00_0000 : pat(s, k)), "demux");
      end
    end
    for (i = 0; i < 6 && link_tx_frame !== 1'b1; i++) @(negedge ref_clk);
    if (i == 6) begin
      cmp(1'b0, "no transmit frame");
      complete_run();
    end
    cmp(dw_tx_frame === 1'b1, "double-wire frame strobe");
    @(negedge ref_clk);
    cmp(n_frames - nf == 1, "frame strobes per base frame");
  endtask : run_frame
  task automatic set_mode(input bit d, input bit q, input bit b48, input int prime);
    @(negedge ref_clk);
    double_rate_mode    = d;
    quadruple_rate_mode = q;
    base_is_48k         = b48;
    run_frame(prime, 1'b0, 1'b0);
  endtask : set_mode
  task automatic wait_loop();
    int i;
    for (i = 0; i < 10 && link_rx_frame !== 1'b1; i++) @(negedge ref_clk);
    if (i == 10) begin
      cmp(1'b0, "partner frame missing");
      complete_run();
    end
  endtask : wait_loop
  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    cmp(rate_factor === FACTOR_SINGLE, "reset factor");
    cmp(internal_rate_hz === 17'(BASE_48_HZ), "reset rate");
    cmp(link_tx_frame === 1'b0 && snk_valid === 1'b0, "reset strobes");
  endtask : t_reset
  task automatic t_double(input bit b48);
    set_mode(1'b1, 1'b0, b48, 1);
    cmp(rate_factor === FACTOR_DOUBLE, "double factor");
    cmp(internal_rate_hz === 17'(2 * (b48 ? BASE_48_HZ : BASE_441_HZ)), "double rate");
    cmp(active_rate_double === 1'b1 && active_rate_quad === 1'b0, "double active");
    run_frame(2, 1'b0, 1'b0);
    for (int s = 0; s < SOURCES; s++)
      for (int k = 0; k < 2; k++)
        cmp(link_tx[((s / 4) * 8 + (s % 4) * 2 + k)*SAMPLE_W+:SAMPLE_W] === pat(s, k), "double lane");
    cmp(dw_tx === {pat(0, 1), pat(0, 0)}, "double-wire subframes");
    wait_loop();
    run_frame(2, 1'b1, 1'b0);
    set_mode(1'b0, 1'b0, b48, 2);
    cmp(rate_factor === FACTOR_SINGLE && channel_limit === 5'h08, "back to single");
  endtask : t_double
  task automatic t_quad();
    set_mode(1'b1, 1'b1, 1'b1, 1); // both requests up: quad must win
    cmp(rate_factor === FACTOR_QUAD && active_rate_quad === 1'b1, "quad factor");
    cmp(channel_limit === 5'(QUAD_CH_LIMIT), "quad channel limit");
    cmp(internal_rate_hz === 17'(2 * BASE_48_HZ), "quad reported rate");
    run_frame(4, 1'b0, 1'b1);
    for (int s = 0; s < QUAD_SOURCES; s++)
      for (int k = 0; k < 4; k++)
        cmp(link_tx[(s * 4 + k)*SAMPLE_W+:SAMPLE_W] === pat(s, k), "quad lane");
    wait_loop();
    run_frame(4, 1'b1, 1'b1);
    set_mode(1'b0, 1'b0, 1'b1, 4);
  endtask : t_quad
  //////////////////////////////////////////////////////////////////////
  initial begin
    err_total           = 0;
    comparisons         = 0;
    n_frames            = 0;
    rst_b               = 1'b0;
    double_rate_mode    = 1'b0;
    quadruple_rate_mode = 1'b0;
    base_is_48k         = 1'b1;
    base_tick           = 1'b0;
    slot_tick           = 1'b0;
    src_sample          = '0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_double(1'b0);
    t_double(1'b1);
    t_quad();
    complete_run();
  end
endmodule : tb_top
